// ### rtl/dcr_pkg.sv
`default_nettype none
package dcr_pkg;
  localparam int          N_CHAN        = 14;
  localparam int          CC_W          = 3;
  localparam logic [2:0]  CC_INVALID    = 3'h0;
  localparam logic [31:0] ADDR_PRIO_SET = 32'h4001_0038;
  localparam logic [31:0] ADDR_PRIO_CLR = 32'h4001_003C;
  localparam logic [31:0] ADDR_ERR      = 32'h4001_004C;
  localparam logic [31:0] ADDR_SWAP_SET = 32'h4001_0800;
  localparam logic [31:0] ADDR_SWAP_CLR = 32'h4001_0804;
  localparam logic [31:0] ADDR_ISTA     = 32'h4001_0900;
  localparam logic [31:0] ADDR_IMASK    = 32'h4001_0904;
  localparam logic [31:0] ADDR_EN_SET   = 32'h4001_0908;
  localparam logic [31:0] ADDR_EN_CLR   = 32'h4001_090C;
  localparam logic [13:0] RST_CHAN      = 14'h0000;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// ### rtl/dcr_set_clr.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_set_clr
  import dcr_pkg::*;
#(
  parameter int         W        = N_CHAN,
  parameter bit         SET_WINS = 1'b1,
  parameter logic [W-1:0] RST    = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Bit controls
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_next;

  // A set arriving with its clear survives unless the owner lets clear win
  assign q_next = SET_WINS ? ((q & ~clr) | set) : ((q | set) & ~clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= RST;
    else q <= q_next;
  end
endmodule
`default_nettype wire

// ### rtl/dcr_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_axil_slave
  import dcr_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register side
  output logic             wr_en,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_en,
  output logic [31:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_full_reg;
  logic w_full_reg;
  logic ar_full_reg;
  logic aw_full_next;
  logic w_full_next;
  logic ar_full_next;

  // Address and data are held until both are in, in either order
  assign wr_en        = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_en        = ar_full_reg && !s_axi_rvalid;
  assign aw_full_next = aw_full_reg ? !wr_en : (s_axi_awvalid && s_axi_awready);
  assign w_full_next  = w_full_reg ? !wr_en : (s_axi_wvalid && s_axi_wready);
  assign ar_full_next = ar_full_reg ? !rd_en : (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      ar_full_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
      wr_addr       <= RST_WORD;
      wr_data       <= RST_WORD;
      wr_strb       <= 4'h0;
      rd_addr       <= RST_WORD;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= RST_WORD;
    end else begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      ar_full_reg   <= ar_full_next;
      s_axi_awready <= !aw_full_next;
      s_axi_wready  <= !w_full_next;
      s_axi_arready <= !ar_full_next;
      if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata  <= rd_data;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/dcr_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcr_top
  import dcr_pkg::*;
#(
  parameter int NCH = N_CHAN
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Channel events from the transfer engine
  input  wire logic [NCH-1:0]    chan_bus_err,
  input  wire logic [NCH-1:0]    desc_fetch,
  input  wire logic [NCH*CC_W-1:0] desc_cycle_ctrl,
  // Channel controls
  output logic      [NCH-1:0]    chan_enable,
  output logic      [NCH-1:0]    chan_high_prio,
  output logic      [NCH-1:0]    chan_swap_en,
  // Interrupt
  output logic                   irq
);
  logic           wr_en;
  logic [31:0]    wr_addr;
  logic [31:0]    wr_data;
  logic [3:0]     wr_strb;
  logic           wr_ok;
  logic           rd_en;
  logic [31:0]    rd_addr;
  logic [31:0]    rd_data;
  logic           rd_ok;
  logic [NCH-1:0] lane_mask;
  logic [NCH-1:0] wr_bits;
  logic [NCH-1:0] wr_zeros;
  logic [NCH-1:0] err_evt;
  logic [NCH-1:0] err_flags;
  logic [NCH-1:0] ista;
  logic [NCH-1:0] imask;
  logic [NCH-1:0] none;
  logic [NCH-1:0] all_ones;
  logic           irq_reg;
  logic           irq_next;

  dcr_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Per-channel byte lanes and error events
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_chan
      assign lane_mask[c] = wr_strb[c/8];
      assign err_evt[c]   = chan_bus_err[c] ||
                            (desc_fetch[c] && desc_cycle_ctrl[c*CC_W +: CC_W] == CC_INVALID);
    end
  endgenerate

  // Upper data bits are never looked at, so writes there vanish
  assign wr_bits  = wr_data[NCH-1:0] & lane_mask;
  assign wr_zeros = ~wr_data[NCH-1:0] & lane_mask;
  assign none     = '0;
  assign all_ones = '1;

  // Write decode
  wire w_prio_set = wr_en && (wr_addr == ADDR_PRIO_SET);
  wire w_prio_clr = wr_en && (wr_addr == ADDR_PRIO_CLR);
  wire w_err      = wr_en && (wr_addr == ADDR_ERR);
  wire w_swap_set = wr_en && (wr_addr == ADDR_SWAP_SET);
  wire w_swap_clr = wr_en && (wr_addr == ADDR_SWAP_CLR);
  wire w_imask    = wr_en && (wr_addr == ADDR_IMASK);
  wire w_en_set   = wr_en && (wr_addr == ADDR_EN_SET);
  wire w_en_clr   = wr_en && (wr_addr == ADDR_EN_CLR);
  wire w_ista     = wr_en && (wr_addr == ADDR_ISTA);
  assign wr_ok = w_prio_set || w_prio_clr || w_err || w_swap_set || w_swap_clr ||
                 w_imask || w_en_set || w_en_clr || w_ista;

  // Read decode; write-only locations read zero rather than erroring
  wire r_ista = rd_en && (rd_addr == ADDR_ISTA);
  wire [NCH-1:0] rd_bits =
    (rd_addr == ADDR_PRIO_SET) ? chan_high_prio :
    (rd_addr == ADDR_ERR)      ? err_flags :
    (rd_addr == ADDR_SWAP_SET) ? chan_swap_en :
    (rd_addr == ADDR_ISTA)     ? ista :
    (rd_addr == ADDR_IMASK)    ? imask :
    (rd_addr == ADDR_EN_SET)   ? chan_enable : none;
  assign rd_data = {{(32-NCH){1'b0}}, rd_bits};
  assign rd_ok = (rd_addr == ADDR_PRIO_SET) || (rd_addr == ADDR_PRIO_CLR) ||
                 (rd_addr == ADDR_ERR) || (rd_addr == ADDR_SWAP_SET) ||
                 (rd_addr == ADDR_SWAP_CLR) || (rd_addr == ADDR_ISTA) ||
                 (rd_addr == ADDR_IMASK) || (rd_addr == ADDR_EN_SET) ||
                 (rd_addr == ADDR_EN_CLR);

  // Priority mask: set and clear live at separate addresses
  dcr_set_clr #(.W(NCH), .SET_WINS(1'b1), .RST(RST_CHAN)) u_prio (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (w_prio_set ? wr_bits : none),
    .clr     (w_prio_clr ? wr_bits : none),
    .q       (chan_high_prio)
  );

  // Error flags; a new error beats a simultaneous clear
  dcr_set_clr #(.W(NCH), .SET_WINS(1'b1), .RST(RST_CHAN)) u_err (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (err_evt),
    .clr     (w_err ? wr_bits : none),
    .q       (err_flags)
  );

  dcr_set_clr #(.W(NCH), .SET_WINS(1'b1), .RST(RST_CHAN)) u_swap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (w_swap_set ? wr_bits : none),
    .clr     (w_swap_clr ? wr_bits : none),
    .q       (chan_swap_en)
  );

  // Channel enable; the fault disable wins over an enable set in the same cycle
  dcr_set_clr #(.W(NCH), .SET_WINS(1'b0), .RST(RST_CHAN)) u_en (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (w_en_set ? wr_bits : none),
    .clr     (err_evt | (w_en_clr ? wr_bits : none)),
    .q       (chan_enable)
  );

  // Interrupt status, cleared by reading it
  dcr_set_clr #(.W(NCH), .SET_WINS(1'b1), .RST(RST_CHAN)) u_ista (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (err_evt),
    .clr     (r_ista ? all_ones : none),
    .q       (ista)
  );

  dcr_set_clr #(.W(NCH), .SET_WINS(1'b1), .RST(RST_CHAN)) u_imask (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (w_imask ? wr_bits : none),
    .clr     (w_imask ? wr_zeros : none),
    .q       (imask)
  );

  // Registered so the pin is glitch free; lags status by one cycle
  assign irq_next = |(ista & imask);
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_reg <= 1'b0;
    else irq_reg <= irq_next;
  end
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_to(logic [31:0] a);
    wr_en && (wr_addr == a);
  endsequence

  sequence s_err_hit;
    |err_evt;
  endsequence

  sequence s_rd_of(logic [31:0] a);
    rd_en && (rd_addr == a);
  endsequence

  prio_clear_a: assert property (
    s_wr_to(ADDR_PRIO_CLR) |=> ((chan_high_prio & $past(wr_bits)) == '0))
    else $error("priority clear left a channel high");

  prio_no_raise_a: assert property (
    s_wr_to(ADDR_PRIO_CLR) |=> ((chan_high_prio & ~$past(chan_high_prio)) == '0))
    else $error("priority clear raised a channel");

  prio_set_a: assert property (
    s_wr_to(ADDR_PRIO_SET) |=> ((~chan_high_prio & $past(wr_bits)) == '0))
    else $error("priority set did not raise a channel");

  err_set_a: assert property (
    s_err_hit |=> ((err_flags & $past(err_evt)) == $past(err_evt)) [*2])
    else $error("error event not recorded");

  chan_off_a: assert property (
    (s_err_hit and !wr_en) |=>
      ((chan_enable & $past(err_evt)) == '0) &&
      (((chan_enable ^ $past(chan_enable)) & ~$past(err_evt)) == '0))
    else $error("error disable touched the wrong channel");

  err_read_a: assert property (
    (rd_en && rd_addr == ADDR_ERR) |=> s_axi_rvalid && (s_axi_rdata[NCH-1:0] == $past(err_flags)))
    else $error("error register read wrong value");

  err_clear_a: assert property (
    (s_wr_to(ADDR_ERR) and !(|err_evt)) |=>
      ((err_flags & $past(wr_bits)) == '0) && ((err_flags & ~$past(wr_bits)) == $past(err_flags & ~wr_bits)))
    else $error("error clear misbehaved");

  swap_set_a: assert property (
    s_wr_to(ADDR_SWAP_SET) |=> ((chan_swap_en & $past(wr_bits)) == $past(wr_bits)) &&
                               ((chan_swap_en & $past(chan_swap_en)) == $past(chan_swap_en)))
    else $error("swap set misbehaved");

  swap_read_a: assert property (
    (rd_en && rd_addr == ADDR_SWAP_SET) |-> ##1 (s_axi_rdata[NCH-1:0] == $past(chan_swap_en)))
    else $error("swap readback wrong");

  swap_clr_a: assert property (
    s_wr_to(ADDR_SWAP_CLR) |=> ((chan_swap_en & $past(wr_bits)) == '0) &&
                               ((chan_swap_en & ~$past(chan_swap_en)) == '0))
    else $error("swap clear misbehaved");

  reset_zero_a: assert property (
    $rose(aresetn) |-> (err_flags == '0) && (chan_swap_en == '0))
    else $error("flags not zero after reset");

  upper_zero_a: assert property (
    s_axi_rvalid |-> (s_axi_rdata[31:NCH] == '0))
    else $error("upper read bits not zero");

  lsb_chan_a: assert property (
    (chan_bus_err == {{(NCH-1){1'b0}}, 1'b1}) |=> err_flags[0])
    else $error("channel zero not on bit zero");

  prio_keep_a: assert property (
    s_wr_to(ADDR_PRIO_CLR) |=>
      (((chan_high_prio ^ $past(chan_high_prio)) & ~$past(wr_bits)) == '0))
    else $error("priority clear touched an unselected channel");

  swap_keep_a: assert property (
    s_wr_to(ADDR_SWAP_CLR) |=>
      (((chan_swap_en ^ $past(chan_swap_en)) & ~$past(wr_bits)) == '0))
    else $error("swap clear touched an unselected channel");

  idle_hold_a: assert property (
    !wr_en |=> $stable(chan_high_prio) && $stable(chan_swap_en))
    else $error("priority or swap changed without a write");

  prio_clr_read_a: assert property (
    s_rd_of(ADDR_PRIO_CLR) |=> (s_axi_rdata == RST_WORD))
    else $error("priority clear register read back data");

  swap_clr_read_a: assert property (
    s_rd_of(ADDR_SWAP_CLR) |=> (s_axi_rdata == RST_WORD))
    else $error("swap clear register read back data");

  // A status read empties the word unless a new error lands with it
  ista_clear_a: assert property (
    (s_rd_of(ADDR_ISTA) and !(|err_evt)) |=> (ista == '0))
    else $error("status read did not clear");

  en_set_a: assert property (
    (s_wr_to(ADDR_EN_SET) and !(|err_evt)) |=>
      ((chan_enable & $past(wr_bits)) == $past(wr_bits)))
    else $error("enable set did not start a channel");
endmodule
`default_nettype wire

// ### tb/dcr_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Transfer engine stand-in: one-cycle event pulses on command
module dcr_engine_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Command from the bench: kind 1 bus error, 2 bad descriptor, 3 good descriptor
  input  wire logic        ev_go,
  input  wire logic [3:0]  ev_chan,
  input  wire logic [1:0]  ev_kind,
  // Event outputs
  output logic      [13:0] chan_bus_err,
  output logic      [13:0] desc_fetch,
  output logic      [41:0] desc_cycle_ctrl
);
  logic [41:0] junk;
  logic [41:0] ccv;
  int          ci;
  // Idle cycle-control fields churn so a stale 000 never looks like a fetch
  always @(posedge aclk) begin
    junk <= junk + 42'h1_5555_5555;
    chan_bus_err <= '0;
    desc_fetch <= '0;
    ccv = junk;
    ci = int'(ev_chan);
    if (aresetn && ev_go) begin
      if (ev_kind == 2'h1) chan_bus_err[ci] <= 1'b1;
      else begin
        desc_fetch[ci] <= 1'b1;
        ccv[3*ci +: 3] = (ev_kind == 2'h2) ? 3'h0 : 3'h5;
      end
    end
    desc_cycle_ctrl <= ccv;
  end
  initial junk = 42'h0;
endmodule
`default_nettype wire

// ### tb/dma_channel_ctrl_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_ctrl_regs_test;
  import dcr_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ev_go;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb, ev_chan;
  logic [1:0]  bresp, rresp, ev_kind;
  logic [13:0] bus_err, fetch, chan_en, hi_prio, swap_en;
  logic [41:0] cc;
  int          n_fail, checks_done;

  dcr_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_bus_err(bus_err), .desc_fetch(fetch), .desc_cycle_ctrl(cc),
    .chan_enable(chan_en), .chan_high_prio(hi_prio), .chan_swap_en(swap_en), .irq(irq)
  );

  dcr_engine_model eng_u (
    .aclk(aclk), .aresetn(aresetn), .ev_go(ev_go), .ev_chan(ev_chan), .ev_kind(ev_kind),
    .chan_bus_err(bus_err), .desc_fetch(fetch), .desc_cycle_ctrl(cc)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Address and data offered together; each dropped once its own ready is seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a lost answer
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
  endtask

  // Registered outputs trail the register by a cycle
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask

  task automatic ev(input logic [3:0] c, input logic [1:0] k);
    @(posedge aclk);
    ev_go <= 1'b1;
    ev_chan <= c;
    ev_kind <= k;
    @(posedge aclk);
    ev_go <= 1'b0;
    settle;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ev_go} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    ev_chan = 4'h0;
    ev_kind = 2'h0;
    n_fail = 0;
    checks_done = 0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_ERR, RST_WORD, RESP_OKAY);
    rd(ADDR_SWAP_SET, RST_WORD, RESP_OKAY);
    chk({18'h0, swap_en}, RST_WORD);
    // Swap enables, with only the upper byte lane strobed on the clear
    wr(ADDR_SWAP_SET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rd(ADDR_SWAP_SET, 32'h0000_3FFF, RESP_OKAY);
    wr(ADDR_SWAP_CLR, 32'h0000_3FFF, 4'h2, RESP_OKAY);
    wr(ADDR_SWAP_CLR, 32'h0000_0000, 4'hF, RESP_OKAY);
    rd(ADDR_SWAP_SET, 32'h0000_00FF, RESP_OKAY);
    rd(ADDR_SWAP_CLR, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_SWAP_SET, 32'h0000_2000, 4'hF, RESP_OKAY);
    settle;
    chk({18'h0, swap_en}, 32'h0000_20FF);
    // Priority
    wr(ADDR_PRIO_SET, 32'h0000_2001, 4'hF, RESP_OKAY);
    wr(ADDR_PRIO_CLR, 32'hFFFF_C001, 4'hF, RESP_OKAY);
    wr(ADDR_PRIO_CLR, 32'h0000_0000, 4'hF, RESP_OKAY);
    rd(ADDR_PRIO_SET, 32'h0000_2000, RESP_OKAY);
    rd(ADDR_PRIO_CLR, 32'h0000_0000, RESP_OKAY);
    settle;
    chk({18'h0, hi_prio}, 32'h0000_2000);
    // Errors: highest and lowest channel, plus a harmless good descriptor
    wr(ADDR_EN_SET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    ev(4'd0, 2'h1);
    ev(4'd13, 2'h2);
    ev(4'd5, 2'h3);
    rd(ADDR_ERR, 32'h0000_2001, RESP_OKAY);
    chk({18'h0, chan_en}, 32'h0000_1FFE);
    wr(ADDR_EN_CLR, 32'h0000_0002, 4'hF, RESP_OKAY);
    rd(ADDR_EN_SET, 32'h0000_1FFC, RESP_OKAY);
    rd(ADDR_EN_CLR, 32'h0000_0000, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_ERR, 32'h0000_0000, 4'hF, RESP_OKAY);
    rd(ADDR_ERR, 32'h0000_2001, RESP_OKAY);
    wr(ADDR_ERR, 32'h0000_0001, 4'hF, RESP_OKAY);
    rd(ADDR_ERR, 32'h0000_2000, RESP_OKAY);
    // Interrupt: unmask, then a status read clears it
    wr(ADDR_IMASK, 32'h0000_2000, 4'hF, RESP_OKAY);
    rd(ADDR_IMASK, 32'h0000_2000, RESP_OKAY);
    settle;
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_ISTA, 32'h0000_2001, RESP_OKAY);
    settle;
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_ISTA, 32'h0000_0000, RESP_OKAY);
    // Unmapped address
    wr(32'h4001_0010, 32'h0000_0001, 4'hF, RESP_SLVERR);
    rd(32'h4001_0010, 32'h0000_0000, RESP_SLVERR);
    // Reset again while error, swap and priority bits are set
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_ERR, RST_WORD, RESP_OKAY);
    rd(ADDR_SWAP_SET, RST_WORD, RESP_OKAY);
    chk({18'h0, swap_en | hi_prio | chan_en}, RST_WORD);
    finish_test;
  end

  // Whole run is under two hundred cycles; this is far beyond it
  initial begin
    repeat (3000) @(posedge aclk);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
